/* File: rtl/conv_control_two.sv */
// Converter control register two with AXI4-Lite slave and interrupt logic.
// Assumes the converter core pulses conv_done once per completed conversion.
`default_nettype none
// Contract
// R01 - Reference field has no effect; rails always
// R02 - Scan bit enables primary positive input scan
// R03 - Channel count: one, two, or four channels
// R04 - Twelve-bit mode: count reads zero, primary only
// R05 - Fill status shows half being filled
// R06 - Software reads the half not being filled
// R07 - No DMA: interrupt every low-four-plus-one conversions
// R08 - DMA: address step every five-bit-plus-one conversions
// R09 - Bits 12 and 11 read zero, reset zero
// R10 - Split buffer halves; alternate input selectors
module conv_control_two
  import conv_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter core side
  input wire logic conv_done,
  output logic [1:0] ref_select,
  output logic input_scan_select,
  output logic [3:0] channel_enable,
  output logic split_buffer_mode,
  output logic alternate_input_select,
  output logic buffer_fill_half_status,
  output logic dma_address_step,
  // Interrupt
  output logic irq
);
  import conv_ctrl_pkg::*;

  conv_event_if ev ();

  logic [15:0] ctrl_reg, ctrl_next;
  logic [1:0] mode_reg, mode_next;
  logic [1:0] stat_reg, stat_next;
  logic [1:0] mask_reg, mask_next;
  logic [3:0] aw_addr_reg, aw_addr_next;
  logic aw_full_reg, aw_full_next;
  logic [15:0] w_data_reg, w_data_next;
  logic [1:0] w_strb_reg, w_strb_next;
  logic w_full_reg, w_full_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [15:0] ctrl_view;
  logic wr_fire, rd_fire;
  logic [3:0] chan_en_reg, chan_en_next;
  logic irq_reg, irq_next;

  // Merge a 16-bit word with two byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0] strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  function automatic logic known_offset(input logic [3:0] a);
    return (a == OFS_CONTROL_TWO) || (a == OFS_IRQ_STATUS) ||
           (a == OFS_IRQ_MASK) || (a == OFS_MODE);
  endfunction

  // Channel set from the count field; twelve-bit mode keeps only the primary
  // channel whatever the stored count bits hold
  function automatic logic [3:0] chan_decode(input logic [15:0] ctrl_v,
                                             input logic twelve);
    logic [3:0] res;
    if (twelve) begin
      res = 4'h1; // R04
    end else if (ctrl_v[CHAN_LSB + 1]) begin
      res = 4'hF; // R03
    end else if (ctrl_v[CHAN_LSB]) begin
      res = 4'h3; // R03
    end else begin
      res = 4'h1; // R03
    end
    return res;
  endfunction

  // Readback view: fill status live, channel count hidden in twelve-bit mode
  // The stored count bits survive a trip through twelve-bit mode
  always_comb begin
    ctrl_view = ctrl_reg & CTRL_WMASK; // R09
    ctrl_view[FILL_BIT] = ev.fill_half; // R05
    if (mode_reg[MODE_TWELVE_BIT]) begin
      ctrl_view[CHAN_LSB +: 2] = 2'b00; // R04
    end
  end

  // Write path: address and data accepted independently, response after both
  // Committing only with both halves present keeps stale data out of the register
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    aw_addr_next = aw_addr_reg;
    aw_full_next = aw_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    w_full_next = w_full_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    mask_next = mask_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_next = s_axi_awaddr;
      aw_full_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_data_next = s_axi_wdata[15:0];
      w_strb_next = s_axi_wstrb[1:0];
      w_full_next = 1'b1;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = known_offset(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      unique case (aw_addr_reg)
        OFS_CONTROL_TWO: begin
          // Read-only and unimplemented bits ignore writes
          ctrl_next = merge16(ctrl_reg, w_data_reg, w_strb_reg) & CTRL_WMASK; // R09
        end
        OFS_IRQ_MASK: begin
          if (w_strb_reg[0]) begin
            mask_next = w_data_reg[1:0];
          end
        end
        OFS_MODE: begin
          if (w_strb_reg[0]) begin
            mode_next = w_data_reg[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // Read path and sticky status: a set wins over the clear-on-read
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    stat_next = stat_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = known_offset(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CONTROL_TWO: begin
          rdata_next = {16'h0000, ctrl_view};
        end
        OFS_IRQ_STATUS: begin
          rdata_next = {30'h00000000, stat_reg};
          stat_next = 2'b00;
        end
        OFS_IRQ_MASK: begin
          rdata_next = {30'h00000000, mask_reg};
        end
        OFS_MODE: begin
          rdata_next = {30'h00000000, mode_reg};
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
    if (ev.irq_pulse) begin
      stat_next[IRQ_CONV_BIT] = 1'b1; // R07
    end
    if (ev.dma_step) begin
      stat_next[IRQ_DMA_BIT] = 1'b1; // R08
    end
  end

  // Register all state except the two output registers below
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET; // R09
      mode_reg <= 2'h0;
      stat_reg <= IRQ_RESET;
      mask_reg <= IRQ_RESET;
      aw_addr_reg <= 4'h0;
      aw_full_reg <= 1'b0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'h0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      aw_addr_reg <= aw_addr_next;
      aw_full_reg <= aw_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      w_full_reg <= w_full_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Handshakes: one write and one read in flight at a time
  // Ready drops while a response waits, so a second write cannot overtake it
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Sequencer configuration into the counter
  // The counter keeps its count across configuration changes
  assign ev.dma_en = mode_reg[MODE_DMA_BIT];
  assign ev.incr = ctrl_reg[INCR_LSB +: 5];
  assign ev.conv_done = conv_done;
  assign ev.split_mode = ctrl_reg[SPLIT_BIT];

  conv_event_counter u_counter (
    .clk_sys(clk_sys),
    .rst(rst),
    .ev(ev)
  );

  // Data outputs are flip-flops fed from next-state values, so they move on
  // the same edge as the registers behind them and never glitch
  always_comb begin
    chan_en_next = chan_decode(ctrl_next, mode_next[MODE_TWELVE_BIT]); // R03 R04
    irq_next = |(stat_next & mask_next); // R07
  end

  // Output registers; reset matches a zero control word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_en_reg <= 4'h1;
      irq_reg <= 1'b0;
    end else begin
      chan_en_reg <= chan_en_next;
      irq_reg <= irq_next;
    end
  end

  // Converter core controls; reference field deliberately unused
  assign ref_select = REF_SUPPLY_RAILS; // R01
  assign input_scan_select = ctrl_reg[SCAN_BIT]; // R02
  assign channel_enable = chan_en_reg; // R03 R04
  assign split_buffer_mode = ctrl_reg[SPLIT_BIT]; // R10
  assign alternate_input_select = ctrl_reg[ALT_BIT]; // R10
  // Software picks the other half from this flag
  assign buffer_fill_half_status = ev.fill_half; // R05 R06
  assign dma_address_step = ev.dma_step; // R08
  assign irq = irq_reg;
endmodule
`default_nettype wire

/* File: rtl/conv_ctrl_pkg.sv */
// Package for the converter control-two block: offsets, fields, reset values.
// Assumes an AXI4-Lite register bus with 32-bit data.
`default_nettype none
package conv_ctrl_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CONTROL_TWO = 4'h0;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
  localparam logic [3:0] OFS_MODE = 4'hC;
  // Field positions in converter_control_two
  localparam int REF_CFG_LSB = 13;
  localparam int SCAN_BIT = 10;
  localparam int CHAN_LSB = 8;
  localparam int FILL_BIT = 7;
  localparam int INCR_LSB = 2;
  localparam int SPLIT_BIT = 1;
  localparam int ALT_BIT = 0;
  // Writable bits: reference, scan, channel count, increment, split, alternate
  localparam logic [15:0] CTRL_WMASK = 16'hE77F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Mode register bits
  localparam int MODE_TWELVE_BIT = 0;
  localparam int MODE_DMA_BIT = 1;
  // Interrupt status bits
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_DMA_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Reference selection codes
  localparam logic [1:0] REF_SUPPLY_RAILS = 2'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states along the usual path
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01
  } seq_state_t;
endpackage
`default_nettype wire

/* File: rtl/conv_event_if.sv */
// Interface carrying the sequencer configuration and its events.
// Assumes a single clock domain; no logic of its own.
`default_nettype none
interface conv_event_if;
  logic dma_en;
  logic [4:0] incr;
  logic conv_done;
  logic split_mode;
  logic irq_pulse;
  logic dma_step;
  logic fill_half;
  modport ctrl (output dma_en, output incr, output conv_done, output split_mode,
    input irq_pulse, input dma_step, input fill_half);
  modport counter (input dma_en, input incr, input conv_done, input split_mode,
    output irq_pulse, output dma_step, output fill_half);
endinterface
`default_nettype wire

/* File: rtl/conv_event_counter.sv */
// Counts completed conversions and emits interrupt or DMA step every N-th.
// Assumes conversion-done pulses synchronous to clk_sys.
`default_nettype none
module conv_event_counter
  import conv_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration and events
  conv_event_if.counter ev
);
  import conv_ctrl_pkg::*;

  seq_state_t state_reg, state_next;
  logic [4:0] count_reg, count_next;
  logic half_reg, half_next;
  logic irq_reg, irq_next;
  logic step_reg, step_next;
  logic [4:0] limit;

  // Without DMA the increment field's top bit is ignored
  always_comb begin
    limit = ev.dma_en ? ev.incr : {1'b0, ev.incr[3:0]}; // R07 R08
    state_next = state_reg;
    count_next = count_reg;
    half_next = half_reg;
    irq_next = 1'b0;
    step_next = 1'b0;
    unique case (state_reg)
      SEQ_IDLE: begin
        if (ev.conv_done) begin
          state_next = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        state_next = SEQ_RUN;
      end
    endcase
    if (ev.conv_done) begin
      if (count_reg >= limit) begin
        // Event after N = limit + 1 conversions
        count_next = 5'h00;
        irq_next = ~ev.dma_en; // R07
        step_next = ev.dma_en; // R08
        half_next = ev.split_mode ? ~half_reg : 1'b0; // R05 R10
      end else begin
        count_next = count_reg + 5'h01;
      end
    end
    if (!ev.split_mode) begin
      half_next = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= SEQ_IDLE;
      count_reg <= 5'h00;
      half_reg <= 1'b0;
      irq_reg <= 1'b0;
      step_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      half_reg <= half_next;
      irq_reg <= irq_next;
      step_reg <= step_next;
    end
  end

  assign ev.irq_pulse = irq_reg;
  assign ev.dma_step = step_reg;
  assign ev.fill_half = half_reg;
endmodule
`default_nettype wire

/* File: verification/conv_core_model.sv */
// Model of the converter core: issues conversion-done pulses on request.
// Assumes one clock; the bench asks for a burst of conversions at a time.
`default_nettype none
module conv_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Burst request from the bench
  input wire logic start,
  input wire logic [5:0] num,
  input wire logic slow,
  // Buffer side
  input wire logic fill_half,
  output logic conv_done,
  output logic read_half,
  output logic busy
);
  logic [5:0] left;
  logic gap;

  // Software reads the half not being filled
  assign read_half = ~fill_half;
  assign busy = left != 6'h00;

  // Slow bursts leave an idle cycle between pulses, prompt ones do not
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left <= 6'h00;
      gap <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (start) begin
        left <= num;
      end else if (left != 6'h00) begin
        if (gap && slow) begin
          gap <= 1'b0;
        end else begin
          conv_done <= 1'b1;
          left <= left - 6'h01;
          gap <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/conv_control_two_sva.sv */
// Checker for the control-two block, attached to its ports by bind.
// Assumes the package is compiled first.
`default_nettype none
module conv_control_two_chk
  import conv_ctrl_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Converter side
  input wire logic conv_done,
  input wire logic [1:0] ref_select,
  input wire logic [3:0] channel_enable,
  input wire logic split_buffer_mode,
  input wire logic buffer_fill_half_status,
  input wire logic dma_address_step
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_ref_rails;
    ref_select == REF_SUPPLY_RAILS;
  endproperty
  a_ref_rails: assert property (p_ref_rails) else $error("reference not rails");
  property p_chan_set;
    channel_enable inside {4'h1, 4'h3, 4'hF};
  endproperty
  a_chan_set: assert property (p_chan_set) else $error("bad channel set");
  property p_step_cause;
    dma_address_step |-> $past(conv_done);
  endproperty
  a_step_cause: assert property (p_step_cause) else $error("step without conversion");
  // Fill status is a register, so allow one cycle after split mode drops
  property p_fill_off;
    !split_buffer_mode ##1 !split_buffer_mode |-> !buffer_fill_half_status;
  endproperty
  a_fill_off: assert property (p_fill_off) else $error("fill half set outside split");
  property p_fill_cause;
    $changed(buffer_fill_half_status) && split_buffer_mode && $past(split_buffer_mode)
      |-> $past(conv_done) || $past(conv_done, 2);
  endproperty
  a_fill_cause: assert property (p_fill_cause) else $error("fill half moved alone");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule

bind conv_control_two conv_control_two_chk u_chk (.clk_sys, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .conv_done, .ref_select, .channel_enable,
  .split_buffer_mode, .buffer_fill_half_status, .dma_address_step);
`default_nettype wire

/* File: verification/adc_sequence_control_two_test.sv */
// Self-checking bench for the converter control-two register block.
// Assumes the core model and the checker are compiled before it.
`default_nettype none
module adc_sequence_control_two_test;
  timeunit 1ns;
  timeprecision 1ns;
  import conv_ctrl_pkg::*;
  logic clk_sys = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, start = 0, slow = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [5:0] num = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_done;
  logic input_scan_select, split_buffer_mode, alternate_input_select, irq, busy, rd_half;
  logic buffer_fill_half_status, dma_address_step;
  logic [1:0] s_axi_bresp, s_axi_rresp, ref_select;
  logic [3:0] channel_enable;
  logic [3:0] ce [4] = '{4'h1, 4'h3, 4'hF, 4'hF};
  logic [33:0] q[$];
  int num_errors = 0, compares = 0, cyc = 0, steps = 0, seed = 32'hbf7f;

  conv_control_two DUT (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .conv_done, .ref_select, .input_scan_select, .channel_enable,
    .split_buffer_mode, .alternate_input_select, .buffer_fill_half_status, .dma_address_step,
    .irq);
  conv_core_model u_core (.clk_sys, .rst, .start, .num, .slow,
    .fill_half(buffer_fill_half_status), .conv_done, .read_half(rd_half), .busy);

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(34'(s_axi_bresp), 34'(RESP_OKAY));
    // An idle edge keeps a following call from re-raising bready in this step
    @(posedge clk_sys);
  endtask

  // Read: expectation noted first, the monitor compares the answer
  task automatic rd(input logic [3:0] a, input logic [33:0] exp);
    q.push_back(exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Burst of conversions, prompt or slow at random
  task automatic conv(input logic [5:0] n);
    start <= 1'b1;
    num <= n;
    slow <= 1'($random(seed));
    @(posedge clk_sys);
    start <= 1'b0;
    @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask

  // Read monitor, step counter and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (dma_address_step) steps++;
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (cyc == 6000) begin
      num_errors++;
      end_sim;
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_CONTROL_TWO, 34'h0);
    wr(OFS_CONTROL_TWO, 32'h0000FFFF);
    rd(OFS_CONTROL_TWO, 34'h0E77F);
    chk(34'({ref_select, input_scan_select, channel_enable}), 34'h1F);
    $display("test fields done");
    // Every channel count code, normal then twelve-bit mode
    for (int m = 0; m < 2; m++) begin
      wr(OFS_MODE, 32'(m));
      for (int c = 0; c < 4; c++) begin
        wr(OFS_CONTROL_TWO, 32'(c << CHAN_LSB));
        chk(34'(channel_enable), m ? 34'h1 : 34'(ce[c]));
        chk(34'(input_scan_select), 34'h0);
        rd(OFS_CONTROL_TWO, m ? 34'h0 : 34'(c << CHAN_LSB));
      end
    end
    $display("test channels done");
    wr(OFS_MODE, 32'h0);
    repeat (4) begin
      d = $random(seed);
      wr(OFS_CONTROL_TWO, d);
      chk(34'({split_buffer_mode, alternate_input_select}), 34'(d[1:0]));
      rd(OFS_CONTROL_TWO, 34'(d[15:0] & CTRL_WMASK));
    end
    $display("test random done");
    // Increment top bit set but ignored without DMA: every third conversion
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_CONTROL_TWO, 32'h12 << INCR_LSB);
    conv(2);
    chk(34'(irq), 34'h0);
    conv(1);
    chk(34'(irq), 34'h1);
    rd(OFS_IRQ_STATUS, 34'h1);
    chk(34'(irq), 34'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    conv(3);
    chk(34'(irq), 34'h0);
    rd(OFS_IRQ_STATUS, 34'h1);
    $display("test interrupt done");
    // With DMA the full five bits count: step every eighteenth conversion
    wr(OFS_MODE, 32'h2);
    wr(OFS_CONTROL_TWO, 32'h11 << INCR_LSB);
    conv(17);
    chk(34'(steps), 34'h0);
    conv(19);
    chk(34'(steps), 34'h2);
    rd(OFS_IRQ_STATUS, 34'h2);
    $display("test dma done");
    wr(OFS_MODE, 32'h0);
    wr(OFS_CONTROL_TWO, 32'h2);
    conv(1);
    chk(34'({buffer_fill_half_status, rd_half}), 34'h2);
    rd(OFS_CONTROL_TWO, 34'h82);
    conv(1);
    chk(34'(buffer_fill_half_status), 34'h0);
    // Leaving split mode must drop a set fill flag
    conv(1);
    wr(OFS_CONTROL_TWO, 32'h0);
    chk(34'(buffer_fill_half_status), 34'h0);
    $display("test split done");
    end_sim;
  end
endmodule
`default_nettype wire
